// ---- src/prot_pkg.sv ----
// constants for the protection stage timing block
// assumes a 200 MHz core clock, 16-bit magnitudes and settings
`default_nettype none
package prot_pkg;
  localparam int CLK_MHZ  = 200;
  localparam int TICK_US  = 1000;
  localparam int TICK_DEF = CLK_MHZ * TICK_US;
  localparam int AW       = 6;
  localparam int DW       = 16;
  localparam int ACC_W    = 40;
  // overcurrent stage s sits at s*OC_STRIDE
  localparam int OC_STRIDE = 4;
  localparam int OC_PICK   = 0;
  localparam int OC_TIME   = 1;
  localparam int OC_CTRL   = 2;
  localparam int OC_HOLD   = 3;
  localparam int NPS_P1    = 16;
  localparam int NPS_T1    = 17;
  localparam int NPS_P2    = 18;
  localparam int NPS_M2    = 19;
  localparam int NPS_CTRL  = 20;
  // voltage stage v (uv1, uv2, ov1, ov2) sits at V_BASE+v*V_STRIDE
  localparam int V_BASE    = 21;
  localparam int V_STRIDE  = 3;
  localparam int V_SET     = 0;
  localparam int V_TIME    = 1;
  localparam int V_CTRL    = 2;
  localparam int NREG      = 33;
  localparam int STAT_OC   = 33;
  localparam int STAT_V    = 34;
  localparam logic [DW-1:0] CFG_RST = 16'h0000;
  // control bits
  localparam int B_EN   = 0;
  localparam int B_INV  = 1;
  localparam int B_IEEE = 2;
  localparam int B_IRST = 3;
  localparam int B_PP   = 2;
  localparam int B_ANY  = 3;
  // 95% drop-off and the 1.2 / 0.6 negative sequence curve
  localparam int DROP_NUM = 19;
  localparam int DROP_DEN = 20;
  localparam int NPS_NUM  = 6;
  localparam int NPS_DEN  = 5;
endpackage
`default_nettype wire

// ---- src/prot_trip_timer.sv ----
// one operate timer: accumulate while started, hold or decay when not
// assumes tick_i is a one-cycle pulse per millisecond on clk_i
`default_nettype none
module prot_trip_timer #(
  parameter int ACC_W = 40,
  parameter int HW    = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             tick_i,
  input  wire logic             inh_i,
  input  wire logic             run_i,
  input  wire logic             drop_i,
  input  wire logic             irst_i,
  input  wire logic [ACC_W-1:0] inc_i,
  input  wire logic [ACC_W-1:0] dec_i,
  input  wire logic [ACC_W-1:0] tgt_i,
  input  wire logic [HW-1:0]    hold_i,
  output logic                  trip_o
);
  logic [ACC_W-1:0] acc_r;
  logic [HW-1:0]    hcnt_r;
  logic [ACC_W:0]   sum;

  assign sum = {1'b0, acc_r} + {1'b0, inc_i};

  ////////////////////////////////////////////////////////////////////////
  // accumulated operate time; saturates instead of wrapping
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || inh_i)
    begin
      acc_r <= '0;
    end
    else if (run_i)
    begin
      if (tick_i && !trip_o)
      begin
        acc_r <= sum[ACC_W] ? '1 : sum[ACC_W-1:0];
      end
    end
    else if (drop_i)
    begin
      if (irst_i)
      begin
        if (tick_i)
        begin
          acc_r <= (acc_r > dec_i) ? acc_r - dec_i : '0;
        end
      end
      else if (hcnt_r >= hold_i)
      begin
        acc_r <= '0;
      end
    end
  end

  // hold counter, restarted by every new start
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || inh_i || run_i || !drop_i || irst_i)
    begin
      hcnt_r <= '0;
    end
    else if (tick_i && hcnt_r < hold_i)
    begin
      hcnt_r <= hcnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || inh_i || !run_i)
    begin
      trip_o <= 1'b0;
    end
    else if (tick_i && sum >= {1'b0, tgt_i})
    begin
      trip_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- src/prot_stage_timing.sv ----
// start, timing and trip logic of the overcurrent, negative sequence,
// undervoltage and overvoltage stages
// assumes magnitudes, blocks and inhibits come from logic on MCLK_I
`default_nettype none
module prot_stage_timing
  import prot_pkg::*;
#(
  parameter int TICK_CYC = TICK_DEF
) (
  input  wire logic          MCLK_I,
  input  wire logic          NRST_I,
  input  wire logic [AW-1:0] ADDR_I,
  input  wire logic [DW-1:0] WDATA_I,
  input  wire logic          WR_I,
  input  wire logic          RD_I,
  output logic      [DW-1:0] RDATA_O,
  input  wire logic [DW-1:0] IA_I,
  input  wire logic [DW-1:0] IB_I,
  input  wire logic [DW-1:0] IC_I,
  input  wire logic [DW-1:0] I2_I,
  input  wire logic [DW-1:0] VA_I,
  input  wire logic [DW-1:0] VB_I,
  input  wire logic [DW-1:0] VC_I,
  input  wire logic [DW-1:0] VAB_I,
  input  wire logic [DW-1:0] VBC_I,
  input  wire logic [DW-1:0] VCA_I,
  input  wire logic [3:0]    OC_TBLK_I,
  input  wire logic [3:0]    OC_INH_I,
  input  wire logic [1:0]    UV_TBLK_I,
  input  wire logic [1:0]    UV_INH_I,
  input  wire logic          BRK_CLOSED_I,
  input  wire logic          VT_FAIL_I,
  output logic      [11:0]   OC_START_O,
  output logic      [11:0]   OC_TRIP_O,
  output logic      [3:0]    OC_START3_O,
  output logic      [3:0]    OC_TRIP3_O,
  output logic      [1:0]    NPS_TRIP_O,
  output logic      [5:0]    UV_TRIP_PP_O,
  output logic      [5:0]    UV_TRIP_PH_O,
  output logic      [1:0]    UV_TRIP3_O,
  output logic      [5:0]    OV_TRIP_PP_O,
  output logic      [5:0]    OV_TRIP_PH_O,
  output logic      [1:0]    OV_TRIP3_O,
  output logic               ANY_START_O
);
  localparam int TW = $clog2(TICK_CYC);

  logic [TW-1:0] tcnt_r;
  logic          tick_r;
  logic [DW-1:0] cfg_r [NREG];
  logic [DW-1:0] iph [3];
  logic [DW-1:0] vpn [3];
  logic [DW-1:0] vpp [3];
  logic [11:0]   oc_st;
  logic [11:0]   oc_tr;
  logic [1:0]    nps_tr;
  logic [11:0]   v_tr;
  logic [3:0]    v_st;
  logic [3:0]    v_pp;
  logic [2:0]    vq [4];

  assign iph[0] = IA_I;
  assign iph[1] = IB_I;
  assign iph[2] = IC_I;
  assign vpn[0] = VA_I;
  assign vpn[1] = VB_I;
  assign vpn[2] = VC_I;
  assign vpp[0] = VAB_I;
  assign vpp[1] = VBC_I;
  assign vpp[2] = VCA_I;

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick: every time setting counts in ms
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      tcnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (tcnt_r == TW'(TICK_CYC - 1))
    begin
      tcnt_r <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      tcnt_r <= tcnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settings; all stages come out of reset disabled
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        cfg_r[i] <= CFG_RST;
      end
    end
    else if (WR_I && ADDR_I < AW'(NREG))
    begin
      cfg_r[ADDR_I] <= WDATA_I;
    end
  end

  // read data stands one cycle only; unmapped reads give zero
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I || !RD_I)
    begin
      RDATA_O <= '0;
    end
    else if (ADDR_I < AW'(NREG))
    begin
      RDATA_O <= cfg_r[ADDR_I];
    end
    else if (ADDR_I == AW'(STAT_OC))
    begin
      RDATA_O <= {5'h00, ANY_START_O, NPS_TRIP_O, OC_TRIP3_O, OC_START3_O};
    end
    else if (ADDR_I == AW'(STAT_V))
    begin
      RDATA_O <= {12'h000, OV_TRIP3_O, UV_TRIP3_O};
    end
    else
    begin
      RDATA_O <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase overcurrent; only stages 1 and 2 have idmt and hold
  for (genvar s = 0; s < 4; s++)
  begin : g_oc
    localparam int B = s * OC_STRIDE;
    logic [DW-1:0] pk;
    logic [DW-1:0] tm;
    logic [DW-1:0] hd;
    logic [3:0]    ct;
    logic          inv;
    logic          irst;
    assign pk   = cfg_r[B+OC_PICK];
    assign tm   = cfg_r[B+OC_TIME];
    assign ct   = cfg_r[B+OC_CTRL][3:0];
    assign hd   = (s < 2) ? cfg_r[B+OC_HOLD] : '0;
    assign inv  = (s < 2) && ct[B_INV];
    assign irst = inv && ct[B_IEEE] && ct[B_IRST];
    for (genvar p = 0; p < 3; p++)
    begin : g_ph
      logic             st;
      logic             dr;
      logic [ACC_W-1:0] inc;
      logic [ACC_W-1:0] dec;
      logic [ACC_W-1:0] tgt;
      assign st  = ct[B_EN] && iph[p] > pk;
      // below 95% of pickup the timer starts to reset
      assign dr  = 21'(iph[p]) * 21'(DROP_DEN)
                   < 21'(pk) * 21'(DROP_NUM);
      // inverse: operate when integral of (i - is) reaches td * is
      assign inc = inv ? ACC_W'(iph[p] - pk) : ACC_W'(1);
      assign dec = ACC_W'(pk - iph[p]);
      assign tgt = inv ? ACC_W'(tm) * ACC_W'(pk) : ACC_W'(tm);
      assign oc_st[s*3+p] = st && !OC_INH_I[s];
      prot_trip_timer #(
        .ACC_W (ACC_W),
        .HW    (DW)
      ) u_tmr (
        .clk_i   (MCLK_I),
        .rst_n_i (NRST_I),
        .tick_i  (tick_r),
        .inh_i   (OC_INH_I[s] || !ct[B_EN]),
        .run_i   (st && !OC_TBLK_I[s]),
        .drop_i  (dr || OC_TBLK_I[s]),
        .irst_i  (irst),
        .inc_i   (inc),
        .dec_i   (dec),
        .tgt_i   (tgt),
        .hold_i  (hd),
        .trip_o  (oc_tr[s*3+p])
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // negative sequence; stage 2 integrates 5*min(i2,2is) to 6*tms*is
  logic [DW:0]      cap2;
  logic [DW:0]      i2m;
  logic [ACC_W-1:0] n2_inc;
  logic [ACC_W-1:0] n2_tgt;
  logic [1:0]       n_en;
  logic             n1_run;
  logic             n2_run;

  assign n_en   = cfg_r[NPS_CTRL][1:0];
  assign cap2   = {cfg_r[NPS_P2], 1'b0};
  assign i2m    = ({1'b0, I2_I} > cap2) ? cap2 : {1'b0, I2_I};
  assign n2_inc = ACC_W'(i2m) * ACC_W'(NPS_DEN);
  assign n2_tgt = ACC_W'(cfg_r[NPS_M2]) * ACC_W'(cfg_r[NPS_P2])
                  * ACC_W'(NPS_NUM);
  assign n1_run = n_en[0] && I2_I > cfg_r[NPS_P1];
  assign n2_run = n_en[1] && I2_I > cfg_r[NPS_P2];

  prot_trip_timer #(
    .ACC_W (ACC_W),
    .HW    (DW)
  ) u_nps1 (
    .clk_i   (MCLK_I),
    .rst_n_i (NRST_I),
    .tick_i  (tick_r),
    .inh_i   (!n_en[0]),
    .run_i   (n1_run),
    .drop_i  (!n1_run),
    .irst_i  (1'b0),
    .inc_i   (ACC_W'(1)),
    .dec_i   ('0),
    .tgt_i   (ACC_W'(cfg_r[NPS_T1])),
    .hold_i  ('0),
    .trip_o  (nps_tr[0])
  );

  prot_trip_timer #(
    .ACC_W (ACC_W),
    .HW    (DW)
  ) u_nps2 (
    .clk_i   (MCLK_I),
    .rst_n_i (NRST_I),
    .tick_i  (tick_r),
    .inh_i   (!n_en[1]),
    .run_i   (n2_run),
    .drop_i  (!n2_run),
    .irst_i  (1'b0),
    .inc_i   (n2_inc),
    .dec_i   ('0),
    .tgt_i   (n2_tgt),
    .hold_i  ('0),
    .trip_o  (nps_tr[1])
  );

  ////////////////////////////////////////////////////////////////////////
  // voltage stages: 0 uv1, 1 uv2, 2 ov1, 3 ov2
  for (genvar v = 0; v < 4; v++)
  begin : g_v
    localparam int B   = V_BASE + v * V_STRIDE;
    localparam bit UND = (v < 2);
    localparam bit ST1 = (v % 2 == 0);
    logic [DW-1:0] set;
    logic [DW-1:0] tm;
    logic [3:0]    ct;
    logic          ih;
    logic          blk;
    logic          inv;
    assign set = cfg_r[B+V_SET];
    assign tm  = cfg_r[B+V_TIME];
    assign ct  = cfg_r[B+V_CTRL][3:0];
    assign inv = ST1 && ct[B_INV];
    // an open breaker must not look like a dead bus to undervoltage
    assign ih  = !ct[B_EN] || (UND && (UV_INH_I[v%2]
                 || !BRK_CLOSED_I || VT_FAIL_I));
    assign blk = UND && UV_TBLK_I[v%2];
    assign v_pp[v] = ct[B_PP];
    assign v_st[v] = (|vq[v]) && !ih;
    for (genvar c = 0; c < 3; c++)
    begin : g_ch
      logic [DW-1:0]    vm;
      logic [DW-1:0]    dv;
      logic             run;
      logic [ACC_W-1:0] inc;
      logic [ACC_W-1:0] tgt;
      assign vm  = ct[B_PP] ? vpp[c] : vpn[c];
      assign vq[v][c] = UND ? vm < set : vm > set;
      assign run = (ct[B_ANY] ? vq[v][c] : &vq[v]) && !blk;
      assign dv  = UND ? set - vm : vm - set;
      // t = k/|m-1|: integrate |v - vs| until k * vs
      assign inc = inv ? ACC_W'(dv) : ACC_W'(1);
      assign tgt = inv ? ACC_W'(tm) * ACC_W'(set) : ACC_W'(tm);
      prot_trip_timer #(
        .ACC_W (ACC_W),
        .HW    (DW)
      ) u_tmr (
        .clk_i   (MCLK_I),
        .rst_n_i (NRST_I),
        .tick_i  (tick_r),
        .inh_i   (ih),
        .run_i   (run),
        .drop_i  (!run),
        .irst_i  (1'b0),
        .inc_i   (inc),
        .dec_i   ('0),
        .tgt_i   (tgt),
        .hold_i  ('0),
        .trip_o  (v_tr[v*3+c])
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag outputs, one register stage after the timers
  always_ff @(posedge MCLK_I)
  begin
    if (!NRST_I)
    begin
      OC_START_O   <= '0;
      OC_TRIP_O    <= '0;
      OC_START3_O  <= '0;
      OC_TRIP3_O   <= '0;
      NPS_TRIP_O   <= '0;
      UV_TRIP_PP_O <= '0;
      UV_TRIP_PH_O <= '0;
      UV_TRIP3_O   <= '0;
      OV_TRIP_PP_O <= '0;
      OV_TRIP_PH_O <= '0;
      OV_TRIP3_O   <= '0;
      ANY_START_O  <= 1'b0;
    end
    else
    begin
      OC_START_O  <= oc_st;
      OC_TRIP_O   <= oc_tr;
      NPS_TRIP_O  <= nps_tr;
      ANY_START_O <= |v_st;
      for (int s = 0; s < 4; s++)
      begin
        OC_START3_O[s] <= |oc_st[s*3+:3];
        OC_TRIP3_O[s]  <= |oc_tr[s*3+:3];
      end
      for (int u = 0; u < 2; u++)
      begin
        UV_TRIP_PP_O[u*3+:3] <= v_tr[u*3+:3] & {3{v_pp[u]}};
        UV_TRIP_PH_O[u*3+:3] <= v_tr[u*3+:3] & {3{!v_pp[u]}};
        UV_TRIP3_O[u]        <= |v_tr[u*3+:3];
        OV_TRIP_PP_O[u*3+:3] <= v_tr[u*3+6+:3] & {3{v_pp[u+2]}};
        OV_TRIP_PH_O[u*3+:3] <= v_tr[u*3+6+:3] & {3{!v_pp[u+2]}};
        OV_TRIP3_O[u]        <= |v_tr[u*3+6+:3];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/prot_stage_timing_chk.sv ----
// checker: stage flag timing and register port answers
// assumes a bind to prot_stage_timing, one clock, sync low reset
`default_nettype none
module prot_stage_timing_chk
  import prot_pkg::*;
(
  input wire logic          MCLK_I,
  input wire logic          NRST_I,
  input wire logic [AW-1:0] ADDR_I,
  input wire logic          RD_I,
  input wire logic [DW-1:0] RDATA_O,
  input wire logic [3:0]    OC_INH_I,
  input wire logic          BRK_CLOSED_I,
  input wire logic          VT_FAIL_I,
  input wire logic [11:0]   OC_START_O,
  input wire logic [11:0]   OC_TRIP_O,
  input wire logic [3:0]    OC_START3_O,
  input wire logic [3:0]    OC_TRIP3_O,
  input wire logic [1:0]    UV_TRIP3_O
);
  logic [3:0] sor;
  logic [3:0] tor;
  assign sor = {|OC_START_O[11:9], |OC_START_O[8:6],
                |OC_START_O[5:3], |OC_START_O[2:0]};
  assign tor = {|OC_TRIP_O[11:9], |OC_TRIP_O[8:6],
                |OC_TRIP_O[5:3], |OC_TRIP_O[2:0]};
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);
  ////////////////////////////////////////////////////////////////////
  property p_start3;
    OC_START3_O == sor;
  endproperty
  a_start3: assert property (p_start3)
    else $error("combined start differs from phase starts");
  // both come out of the same register stage, so no lag between them
  property p_trip3;
    OC_TRIP3_O == tor;
  endproperty
  a_trip3: assert property (p_trip3)
    else $error("combined trip differs from phase trips");
  property p_inh_st;
    OC_INH_I[0] |=> OC_START_O[2:0] == 3'h0;
  endproperty
  a_inh_st: assert property (p_inh_st)
    else $error("start seen while stage inhibited");
  // trip path lags start by the timer register
  property p_inh_tr;
    OC_INH_I[0] [*3] |=> OC_TRIP_O[2:0] == 3'h0 && !OC_TRIP3_O[0];
  endproperty
  a_inh_tr: assert property (p_inh_tr)
    else $error("trip seen while stage inhibited");
  property p_trip_st;
    $rose(OC_TRIP_O[0]) |-> $past(OC_START_O[0]);
  endproperty
  a_trip_st: assert property (p_trip_st)
    else $error("trip rose without a start");
  property p_uv_blk;
    (!BRK_CLOSED_I || VT_FAIL_I) [*4] |-> UV_TRIP3_O == 2'h0;
  endproperty
  a_uv_blk: assert property (p_uv_blk)
    else $error("undervoltage trip with breaker open or vt fail");
  property p_rd_idle;
    !$past(RD_I) |-> RDATA_O == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read answer cycle");
  property p_rd_stat;
    $past(RD_I) && $past(ADDR_I) == STAT_OC
      |-> RDATA_O[7:0] == $past({OC_TRIP3_O, OC_START3_O});
  endproperty
  a_rd_stat: assert property (p_rd_stat)
    else $error("status word differs from flags");
  property p_rd_bad;
    $past(RD_I) && $past(ADDR_I) > 6'h22 |-> RDATA_O == 16'h0000;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read gave data");
endmodule
`default_nettype wire

// ---- tb/psl_model.sv ----
// scheme logic stand-in: blocks, inhibits, breaker and vt status
// assumes the bench sets cmd_i; bits 3:0 oc block, 7:4 oc inhibit,
// 9:8 uv block, 11:10 uv inhibit, 12 breaker closed, 13 vt fail
`default_nettype none
module psl_model (
  input  wire logic        clk_i,
  input  wire logic [13:0] cmd_i,
  output logic      [13:0] psl_o
);
  // launched on the edge, like the real scheme logic scan
  always @(posedge clk_i)
    psl_o <= cmd_i;
endmodule
`default_nettype wire

// ---- tb/test_prot_stage_timing.sv ----
// bench: register setup then stage timing sequences
// assumes a short tick (20 cycles) standing for one millisecond
`default_nettype none
module test_prot_stage_timing
  import prot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 20;
  logic          clk, nrst, wr, rd, any;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, ia, ib, ic, i2, va, vb, vc, vab, vbc, vca;
  logic [13:0]   cmd, psl;
  logic [11:0]   st, tr;
  logic [3:0]    st3, tr3;
  logic [1:0]    nps, uv3, ov3;
  logic [5:0]    uvpp, uvph, ovpp, ovph;
  int            n_mismatch, check_count;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  prot_stage_timing #(.TICK_CYC(T)) dut (
    .MCLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .IA_I(ia), .IB_I(ib), .IC_I(ic), .I2_I(i2),
    .VA_I(va), .VB_I(vb), .VC_I(vc),
    .VAB_I(vab), .VBC_I(vbc), .VCA_I(vca),
    .OC_TBLK_I(psl[3:0]), .OC_INH_I(psl[7:4]),
    .UV_TBLK_I(psl[9:8]), .UV_INH_I(psl[11:10]),
    .BRK_CLOSED_I(psl[12]), .VT_FAIL_I(psl[13]),
    .OC_START_O(st), .OC_TRIP_O(tr), .OC_START3_O(st3),
    .OC_TRIP3_O(tr3), .NPS_TRIP_O(nps), .UV_TRIP_PP_O(uvpp),
    .UV_TRIP_PH_O(uvph), .UV_TRIP3_O(uv3), .OV_TRIP_PP_O(ovpp),
    .OV_TRIP_PH_O(ovph), .OV_TRIP3_O(ov3), .ANY_START_O(any)
  );
  psl_model psl_i (.clk_i(clk), .cmd_i(cmd), .psl_o(psl));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h",
               $time, got, exp);
    end
  endtask
  task automatic wr_reg(input int a, input logic [15:0] d);
    @(posedge clk);
    addr <= a[AW-1:0];
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input int a, input logic [15:0] e);
    @(posedge clk);
    addr <= a[AW-1:0];
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_ms(input int n);
    repeat (n * T) @(posedge clk);
    #1;
  endtask
  // 3 ms pulse, 1 ms gap, 2.5 ms pulse against a 4 ms delay
  task automatic gap_run(input logic e);
    @(posedge clk) ia <= 16'h00C8;
    wait_ms(3);
    @(posedge clk) ia <= 16'h0000;
    wait_ms(1);
    @(posedge clk) ia <= 16'h00C8;
    repeat (50) @(posedge clk);
    #1 chk(16'(tr[0]), 16'(e));
    @(posedge clk) ia <= 16'h0000;
    wait_ms(12);
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    #50000;
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    {nrst, wr, rd, addr, wdata, cmd} = '0;
    {ia, ib, ic, i2, va, vb, vc, vab, vbc, vca} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(OC_CTRL, CFG_RST);
    wr_reg(OC_PICK, 16'h0064);
    wr_reg(OC_TIME, 16'h0004);
    wr_reg(OC_CTRL, 16'h0001);
    rd_reg(OC_TIME, 16'h0004);
    rd_reg(40, 16'h0000);
    @(posedge clk) {ia, ib, ic} <= {3{16'h00C8}};
    @(posedge clk) #1 chk(16'(st[2:0]), 16'h0007);
    chk(16'(st3[0]), 16'h0001);
    wait_ms(6);
    chk(16'(tr[2:0]), 16'h0007);
    chk(16'(tr3[0]), 16'h0001);
    rd_reg(STAT_OC, 16'h0011);
    @(posedge clk) {ia, ib, ic} <= '0;
    wait_ms(1);
    chk(16'(tr[2:0]), 16'h0000);
    gap_run(1'b0);
    wr_reg(OC_HOLD, 16'h000A);
    gap_run(1'b1);
    // blocked timer takes the drop-off path (hold, then reset), so a fresh count trips only after release
    @(posedge clk) cmd <= 14'h0001;
    ia <= 16'h00C8;
    wait_ms(6);
    chk(16'(tr[0]), 16'h0000);
    @(posedge clk) cmd <= 14'h0000;
    wait_ms(6);
    chk(16'(tr[0]), 16'h0001);
    @(posedge clk) cmd <= 14'h0010;
    wait_ms(1);
    chk(16'({st[2:0], tr[2:0]}), 16'h0000);
    @(posedge clk) cmd <= 14'h0000;
    ia <= 16'h0000;
    // ratio 4 is above the cap: stage two still needs 6 ms
    wr_reg(NPS_P1, 16'h0064);
    wr_reg(NPS_T1, 16'h0002);
    wr_reg(NPS_P2, 16'h0064);
    wr_reg(NPS_M2, 16'h000A);
    wr_reg(NPS_CTRL, 16'h0003);
    @(posedge clk) i2 <= 16'h0190;
    wait_ms(4);
    chk(16'(nps), 16'h0001);
    wait_ms(4);
    chk(16'(nps), 16'h0003);
    @(posedge clk) i2 <= 16'h0000;
    wr_reg(V_BASE, 16'h0064);
    wr_reg(V_BASE + 1, 16'h0002);
    wr_reg(V_BASE + 2, 16'h0009);
    wr_reg(V_BASE + 6, 16'h0096);
    wr_reg(V_BASE + 7, 16'h0002);
    wr_reg(V_BASE + 8, 16'h0009);
    @(posedge clk) {va, vb, vc} <= {16'h0032, 16'h00C8, 16'h0078};
    wait_ms(4);
    chk(16'(uv3), 16'h0000);
    chk(16'({ov3, ovph}), 16'h0042);
    chk(16'(any), 16'h0001);
    @(posedge clk) cmd <= 14'h1000;
    wait_ms(4);
    chk(16'({uv3, uvph}), 16'h0041);
    @(posedge clk) cmd <= 14'h3000;
    wait_ms(1);
    chk(16'(uv3), 16'h0000);
    @(posedge clk) cmd <= 14'h1400;
    wait_ms(4);
    chk(16'(uv3), 16'h0000);
    rd_reg(STAT_V, 16'h0004);
    // ov1 inverse on phase-phase, all three phases needed
    @(posedge clk) {vab, vbc, vca} <= {16'h00E1, 16'h00E1, 16'h0000};
    wr_reg(V_BASE + 8, 16'h0007);
    wait_ms(5);
    chk(16'({ov3, ovpp}), 16'h0000);
    @(posedge clk) vca <= 16'h00E1;
    wait_ms(3);
    chk(16'(ov3), 16'h0000);
    wait_ms(2);
    chk(16'({ov3, ovpp, ovph}), 16'h11C0);
    // ratio 1.5 is under the cap: 8 ms, not 6
    @(posedge clk) i2 <= 16'h0096;
    wait_ms(7);
    chk(16'(nps), 16'h0001);
    wait_ms(2);
    chk(16'(nps), 16'h0003);
    // inverse reset decays 100 per ms, so the hold must not apply
    wr_reg(OC_CTRL, 16'h000F);
    wr_reg(V_BASE + 2, 16'h000D);
    @(posedge clk) ia <= 16'h00C8;
    cmd <= 14'h1100;
    vca <= 16'h0000;
    wait_ms(3);
    @(posedge clk) ia <= 16'h0000;
    wait_ms(2);
    @(posedge clk) ia <= 16'h00C8;
    wait_ms(2);
    chk(16'(tr[0]), 16'h0000);
    chk(16'({uv3, uvpp}), 16'h0000);
    wait_ms(1);
    chk(16'(tr[0]), 16'h0001);
    @(posedge clk) cmd <= 14'h1000;
    wait_ms(2);
    chk(16'({uv3, uvpp, uvph}), 16'h1100);
    finish_test();
  end
endmodule
bind prot_stage_timing prot_stage_timing_chk chk_i (
  .MCLK_I, .NRST_I, .ADDR_I, .RD_I, .RDATA_O, .OC_INH_I,
  .BRK_CLOSED_I, .VT_FAIL_I, .OC_START_O, .OC_TRIP_O,
  .OC_START3_O, .OC_TRIP3_O, .UV_TRIP3_O
);
`default_nettype wire
